// >>> core/eic_defines.svh
// constants for the edge interrupt controller
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH
`define EIC_NSRC          3'h6
`define EIC_SRC_NMI       0
`define EIC_SRC_BRK       1
`define EIC_SRC_EXTA      2
`define EIC_SRC_EXTB      3
`define EIC_SRC_WKP       4
`define EIC_SRC_DT        5
`define EIC_VEC_NMI       8'h07
`define EIC_VEC_BRK       8'h08
`define EIC_VEC_EXTA      8'h0E
`define EIC_VEC_EXTB      8'h11
`define EIC_VEC_WKP       8'h12
`define EIC_VEC_DT        8'h13
`define EIC_VEC_NONE      8'h00
`define EIC_VEC_ADDR_SH   1
`define EIC_STACK_STATES  3'h4
`define EIC_FETCH_STATES  3'h2
`define EIC_INTERN_STATES 3'h4
`define EIC_IFETCH_STATES 3'h4
`define EIC_CNT_LAST      3'h1
`define EIC_CNT_STEP      3'h1
`define EIC_STACK_PC_OFS  16'h0002
`define EIC_STACK_CCR_OFS 16'h0004
`endif

// >>> core/eic_pkg.sv
// types for the edge interrupt controller
package eic_pkg;
   typedef struct packed {
      logic ext_a;
      logic ext_b;
      logic wakeup;
   } eic_pins_t;
   typedef struct packed {
      logic enable_wkp;
      logic enable_dt;
      logic enable_b;
      logic enable_a;
   } eic_enables_t;
   typedef enum logic [2:0] {
      EIC_IDLE  = 3'b000,
      EIC_STACK = 3'b001,
      EIC_FETCH = 3'b011,
      EIC_INTRN = 3'b010,
      EIC_IFTCH = 3'b110
   } eic_state_t;
endpackage

// >>> core/eic_edge_flag.sv
// one synchronised edge detector with a sticky request flag
`timescale 1ns/1ns
`default_nettype none
module eic_edge_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   input  wire logic rise_sel,
   input  wire logic func_en,
   input  wire logic clr,
   output logic      flag_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic func_q;
   logic edge_hit;
   logic func_chg;
   logic flag_d;

   // ************************************************
   // edge detection
   // ************************************************
   assign edge_hit = func_en & (rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q));
   assign func_chg = func_en & ~func_q;          // mode switch may look like an edge
   assign flag_d   = (edge_hit | func_chg) | (flag_q & ~clr);

   // synchroniser, history and flag; set beats clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q   <= 1'b1;
         s2_q   <= 1'b1;
         s3_q   <= 1'b1;
         func_q <= 1'b1; // no false mode switch right after reset
         flag_q <= 1'b0;
      end else begin
         s1_q   <= pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         func_q <= func_en;
         flag_q <= flag_d;
      end
   end
endmodule
`default_nettype wire

// >>> core/eic_top.sv
// edge interrupt controller with cpu acceptance sequencer
// Functional notes
// (RQ1) falling edge on nmi pin raises request
// (RQ2) nmi highest, ignores the mask bit
// (RQ3) two request pins, own vectors, edge select
// (RQ4) selected edge on enabled pin sets flag
// (RQ5) per-pin enable bit blocks request
// (RQ6) wakeup pin edge chosen by select bit
// (RQ7) selected wakeup edge sets wakeup flag
// (RQ8) wakeup enable sits with other enables
// (RQ9) direct-transfer flag and enable alongside
// (RQ10) peripheral flags set on event, enable masks
// (RQ11) forward only nmi or enabled flags
// (RQ12) present highest only, others stay pending
// (RQ13) mask bit holds back maskable requests
// (RQ14) accept after instruction, stack pc and ccr
// (RQ15) set mask after stacking, return restores
// (RQ16) form vector address, load start address
// (RQ17) latency 4 stack 2 vector 4+4 states
// (RQ18) all sources disabled right after reset
// (RQ19) word stack access, address bit zero
// (RQ20) port mode change may set flag
// (RQ21) software masks first, waits before clearing
// (RQ22) flags clear only by writing zero
// (RQ23) write one keeps flag, set beats clear
// (RQ24) fixed priority nmi, break, then vector order
`include "eic_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module eic_top (
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  NMI_N,
   input  wire eic_pkg::eic_pins_t    PINS,
   input  wire eic_pkg::eic_pins_t    EDGE_RISE,
   input  wire eic_pkg::eic_pins_t    PORT_FUNC,
   input  wire eic_pkg::eic_enables_t ENABLES,
   input  wire logic                  FLAG_WR,
   input  wire logic [3:0]            FLAG_WDATA,
   input  wire logic                  DT_EVENT,
   input  wire logic                  BREAK_REQ,
   input  wire logic                  MASK_BIT,
   input  wire logic                  INSTR_DONE,
   input  wire logic                  RTE,
   input  wire logic                  FIRST_INSTR_DONE,
   input  wire logic [15:0]           NEXT_PC,
   input  wire logic [15:0]           SP,
   input  wire logic [15:0]           VEC_RDATA,
   output logic [3:0]                 FLAGS,
   output logic                       IRQ_PENDING,
   output logic [7:0]                 IRQ_VECTOR,
   output logic                       ACCEPT,
   output logic                       STACK_WR,
   output logic [15:0]                STACK_ADDR,
   output logic [15:0]                STACK_WDATA,
   output logic                       SET_MASK,
   output logic                       VEC_RD,
   output logic [15:0]                VEC_ADDR,
   output logic                       PC_LOAD,
   output logic [15:0]                PC_VALUE,
   output logic                       HANDLER_START
);
   // ************************************************
   // source flags
   // ************************************************
   logic       nmi1_q, nmi2_q, nmi3_q;
   logic       nmi_flag_q, nmi_flag_d;
   logic       dt_flag_q, dt_flag_d;
   logic       armed_q;
   logic       fa, fb, fw;
   logic [5:0] req;
   logic       nmi_fall;
   logic       clr_nmi;

   // flag clear strobes: write 0 clears, write 1 leaves alone
   logic clr_a, clr_b, clr_w, clr_dt;
   assign clr_a  = FLAG_WR & ~FLAG_WDATA[0]; // RQ22 RQ23
   assign clr_b  = FLAG_WR & ~FLAG_WDATA[1]; // RQ22 RQ23
   assign clr_w  = FLAG_WR & ~FLAG_WDATA[2]; // RQ22 RQ23
   assign clr_dt = FLAG_WR & ~FLAG_WDATA[3]; // RQ9

   // request pin a
   eic_edge_flag u_ext_a (
      .clk      (CLK),
      .rst_n    (RST_N),
      .pin      (PINS.ext_a),
      .rise_sel (EDGE_RISE.ext_a),
      .func_en  (PORT_FUNC.ext_a),
      .clr      (clr_a),
      .flag_q   (fa)
   ); // RQ3 RQ4 RQ20

   // request pin b
   eic_edge_flag u_ext_b (
      .clk      (CLK),
      .rst_n    (RST_N),
      .pin      (PINS.ext_b),
      .rise_sel (EDGE_RISE.ext_b),
      .func_en  (PORT_FUNC.ext_b),
      .clr      (clr_b),
      .flag_q   (fb)
   ); // RQ3 RQ4 RQ20

   // wakeup pin
   eic_edge_flag u_wkp (
      .clk      (CLK),
      .rst_n    (RST_N),
      .pin      (PINS.wakeup),
      .rise_sel (EDGE_RISE.wakeup),
      .func_en  (PORT_FUNC.wakeup),
      .clr      (clr_w),
      .flag_q   (fw)
   ); // RQ6 RQ7 RQ20

   // ************************************************
   // request gating and priority
   // ************************************************
   assign nmi_fall   = ~nmi2_q & nmi3_q;                           // RQ1
   assign dt_flag_d  = DT_EVENT | (dt_flag_q & ~clr_dt);          // RQ9 RQ10 RQ23
   assign nmi_flag_d = nmi_fall | (nmi_flag_q & ~clr_nmi);
   assign req[`EIC_SRC_NMI]  = nmi_flag_q & armed_q;              // RQ11 RQ18
   assign req[`EIC_SRC_BRK]  = BREAK_REQ & armed_q;
   assign req[`EIC_SRC_EXTA] = fa & ENABLES.enable_a & armed_q;   // RQ5 RQ11
   assign req[`EIC_SRC_EXTB] = fb & ENABLES.enable_b & armed_q;   // RQ5 RQ11
   assign req[`EIC_SRC_WKP]  = fw & ENABLES.enable_wkp & armed_q; // RQ8 RQ11
   assign req[`EIC_SRC_DT]   = dt_flag_q & ENABLES.enable_dt & armed_q; // RQ9 RQ10

   // mask bit blocks only the maskable group
   logic nmi_take, brk_take, mask_ok, any_take;
   assign nmi_take = req[`EIC_SRC_NMI];                           // RQ2 RQ13
   assign brk_take = req[`EIC_SRC_BRK];                           // RQ13
   assign mask_ok  = ~MASK_BIT;                                   // RQ13
   assign any_take = nmi_take | brk_take | (mask_ok & |req[5:2]);

   // fixed priority vector pick; the mask bit gates only acceptance and IRQ_PENDING, not the vector
   logic [7:0] win_vec;
   assign win_vec = nmi_take ? `EIC_VEC_NMI :
                    brk_take ? `EIC_VEC_BRK :
                    req[`EIC_SRC_EXTA] ? `EIC_VEC_EXTA :
                    req[`EIC_SRC_EXTB] ? `EIC_VEC_EXTB :
                    req[`EIC_SRC_WKP]  ? `EIC_VEC_WKP :
                    req[`EIC_SRC_DT]   ? `EIC_VEC_DT : `EIC_VEC_NONE; // RQ12 RQ24

   // ************************************************
   // acceptance sequencer
   // ************************************************
   eic_pkg::eic_state_t state_q, state_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [7:0]  vec_q;
   logic [15:0] sp_q;
   logic [15:0] pc_q;
   logic        ccr_q;
   logic        start;
   logic        last;

   assign start   = (state_q == eic_pkg::EIC_IDLE) & any_take & INSTR_DONE; // RQ14
   assign clr_nmi = start & (win_vec == `EIC_VEC_NMI);
   assign last    = (cnt_q == `EIC_CNT_LAST);

   // state walk: 4 stack, 2 vector, 4 internal, 4 fetch states
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q - `EIC_CNT_STEP;
      unique case (state_q)
         eic_pkg::EIC_IDLE: begin
            cnt_d = `EIC_STACK_STATES;
            if (start) state_d = eic_pkg::EIC_STACK;
         end
         eic_pkg::EIC_STACK: begin
            if (last) begin
               state_d = eic_pkg::EIC_FETCH;
               cnt_d   = `EIC_FETCH_STATES;
            end
         end
         eic_pkg::EIC_FETCH: begin
            if (last) begin
               state_d = eic_pkg::EIC_INTRN;
               cnt_d   = `EIC_INTERN_STATES;
            end
         end
         eic_pkg::EIC_INTRN: begin
            if (last) begin
               state_d = eic_pkg::EIC_IFTCH;
               cnt_d   = `EIC_IFETCH_STATES;
            end
         end
         eic_pkg::EIC_IFTCH: begin
            if (last) state_d = eic_pkg::EIC_IDLE;
         end
         default: state_d = eic_pkg::EIC_IDLE;
      endcase
   end // RQ17

   // stack word address, bit 0 forced low
   logic [15:0] sp_word;
   assign sp_word = {sp_q[15:1], 1'b0};                           // RQ19
   logic stk_hi;
   assign stk_hi = (cnt_q == `EIC_STACK_STATES);

   // sequencer registers and outputs
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_q <= eic_pkg::EIC_IDLE;
         cnt_q   <= 3'h0;
         vec_q   <= 8'h00;
         sp_q    <= 16'h0000;
         pc_q    <= 16'h0000;
         ccr_q   <= 1'b0;
         nmi1_q  <= 1'b1;
         nmi2_q  <= 1'b1;
         nmi3_q  <= 1'b1;
         nmi_flag_q <= 1'b0;
         dt_flag_q  <= 1'b0;
         armed_q    <= 1'b0;
         FLAGS         <= 4'h0;
         IRQ_PENDING   <= 1'b0;
         IRQ_VECTOR    <= 8'h00;
         ACCEPT        <= 1'b0;
         STACK_WR      <= 1'b0;
         STACK_ADDR    <= 16'h0000;
         STACK_WDATA   <= 16'h0000;
         SET_MASK      <= 1'b0;
         VEC_RD        <= 1'b0;
         VEC_ADDR      <= 16'h0000;
         PC_LOAD       <= 1'b0;
         PC_VALUE      <= 16'h0000;
         HANDLER_START <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         nmi1_q  <= NMI_N;
         nmi2_q  <= nmi1_q;
         nmi3_q  <= nmi2_q;
         nmi_flag_q <= nmi_flag_d;
         dt_flag_q  <= dt_flag_d;
         if (FIRST_INSTR_DONE) armed_q <= 1'b1;                   // RQ18
         FLAGS       <= {dt_flag_q, fw, fb, fa};
         IRQ_PENDING <= any_take & (state_q == eic_pkg::EIC_IDLE);
         IRQ_VECTOR  <= win_vec;
         ACCEPT      <= start;
         if (start) begin
            vec_q <= win_vec;
            sp_q  <= SP;
            pc_q  <= NEXT_PC;                                     // RQ14
            ccr_q <= MASK_BIT;
         end
         // two word pushes: pc then ccr
         STACK_WR    <= (state_q == eic_pkg::EIC_STACK) & (stk_hi | last);
         STACK_ADDR  <= stk_hi ? sp_word - `EIC_STACK_PC_OFS : sp_word - `EIC_STACK_CCR_OFS; // RQ19
         STACK_WDATA <= stk_hi ? pc_q : {15'h0000, ccr_q};        // RQ14 RQ15
         SET_MASK    <= (state_q == eic_pkg::EIC_STACK) & last;   // RQ15
         VEC_RD      <= (state_q == eic_pkg::EIC_FETCH) & last;   // RQ16
         VEC_ADDR    <= {7'h00, vec_q, 1'b0};                     // RQ16
         // read data stands while VEC_RD is high, so the pc is loaded one cycle later
         PC_LOAD     <= VEC_RD;                                   // RQ16
         if (VEC_RD) PC_VALUE <= VEC_RDATA;                       // RQ16
         HANDLER_START <= (state_q == eic_pkg::EIC_IFTCH) & last; // RQ17
      end
   end

   // ************************************************
   // checks
   // ************************************************
   // gating, priority, sequencer timing, stack and flag checks
   a_reset_quiet: assert property (@(posedge CLK) disable iff (!RST_N) // RQ18
      !armed_q |-> !start) else $error("accept before first instruction");
   a_mask_holds: assert property (@(posedge CLK) disable iff (!RST_N) // RQ13
      (start && MASK_BIT) |-> (nmi_take || brk_take)) else $error("masked accept");
   a_nmi_first: assert property (@(posedge CLK) disable iff (!RST_N) // RQ2 RQ24
      nmi_take |-> win_vec == `EIC_VEC_NMI) else $error("nmi not first");
   a_gate_enable: assert property (@(posedge CLK) disable iff (!RST_N) // RQ5 RQ11
      req[`EIC_SRC_EXTA] |-> ENABLES.enable_a) else $error("disabled source forwarded");
   a_set_mask: assert property (@(posedge CLK) disable iff (!RST_N) // RQ15
      ACCEPT |-> ##4 SET_MASK) else $error("mask not set after stacking");
   a_vec_time: assert property (@(posedge CLK) disable iff (!RST_N) // RQ16 RQ17
      ACCEPT |-> ##6 VEC_RD) else $error("vector fetch late");
   a_handler_time: assert property (@(posedge CLK) disable iff (!RST_N) // RQ17
      ACCEPT |-> ##14 HANDLER_START) else $error("handler start wrong");
   a_stack_even: assert property (@(posedge CLK) disable iff (!RST_N) // RQ19
      STACK_WR |-> !STACK_ADDR[0]) else $error("odd stack address");
   a_flag_keep: assert property (@(posedge CLK) disable iff (!RST_N) // RQ22 RQ23
      (fa && !clr_a) |=> fa) else $error("flag lost");
   a_nmi_edge: assert property (@(posedge CLK) disable iff (!RST_N) // RQ1
      nmi_fall |=> nmi_flag_q) else $error("nmi edge missed");

   // sequencer handshake, captured values, break priority, nmi clear and reset checks
   a_pc_load: assert property (@(posedge CLK) disable iff (!RST_N) // RQ16 RQ17
      ACCEPT |-> ##7 PC_LOAD) else $error("pc load late");
   a_pc_fetched: assert property (@(posedge CLK) disable iff (!RST_N) // RQ16
      PC_LOAD |-> PC_VALUE == $past(VEC_RDATA)) else $error("pc not from vector read");
   a_stack_first: assert property (@(posedge CLK) disable iff (!RST_N) // RQ14
      ACCEPT |=> (STACK_WR && STACK_WDATA == pc_q)) else $error("pc push missing");
   a_ccr_capture: assert property (@(posedge CLK) disable iff (!RST_N) // RQ15
      start |=> ccr_q == $past(MASK_BIT)) else $error("stacked mask wrong");
   a_accept_busy: assert property (@(posedge CLK) disable iff (!RST_N) // RQ14
      ACCEPT |-> state_q == eic_pkg::EIC_STACK) else $error("accept outside sequence");
   a_brk_second: assert property (@(posedge CLK) disable iff (!RST_N) // RQ24
      (brk_take && !nmi_take) |-> win_vec == `EIC_VEC_BRK) else $error("break priority wrong");
   a_nmi_clear: assert property (@(posedge CLK) disable iff (!RST_N) // RQ2
      (start && nmi_take && !nmi_fall) |=> !nmi_flag_q) else $error("nmi flag kept");
   a_flags_reset: assert property (@(posedge CLK) // RQ22
      !RST_N |=> FLAGS == 4'h0) else $error("flags not cleared by reset");
endmodule
`default_nettype wire

// >>> verif/eic_cpu_model.sv
// cpu-side partner model: instruction boundaries, mask bit and vector memory
`timescale 1ns/1ns
`default_nettype none
module eic_cpu_model #(
   parameter int PERIOD = 4
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        set_mask,
   input  wire logic        rte,
   input  wire logic        vec_rd,
   input  wire logic [15:0] vec_addr,
   output logic             instr_done,
   output logic             mask_bit,
   output logic [15:0]      vec_rdata
);
   logic [7:0]  cnt_q;
   logic [15:0] junk_q;
   // instruction boundary every PERIOD cycles, mask bit set on reset and by the sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q    <= 8'h00;
         mask_bit <= 1'b1;
      end else begin
         cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
         if (set_mask)
            mask_bit <= 1'b1;
         else if (rte)
            mask_bit <= 1'b0;
      end
   end
   // junk pattern changes every cycle so a stale read never looks right
   always_ff @(posedge clk) begin
      if (!rst_n)
         junk_q <= 16'hA5A5;
      else
         junk_q <= junk_q + 16'h1357;
   end
   assign instr_done = (cnt_q == 8'(PERIOD - 1));
   assign vec_rdata  = vec_rd ? (16'hC000 | vec_addr) : ~junk_q;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking testbench for the edge interrupt controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic CLK = 1'b0, RST_N = 1'b0, NMI_N = 1'b1, FLAG_WR = 1'b0, DT_EVENT = 1'b0, BREAK_REQ = 1'b0;
   logic RTE = 1'b0, FIRST_INSTR_DONE = 1'b0, MASK_BIT, INSTR_DONE;
   eic_pkg::eic_pins_t    PINS = 3'h0, EDGE_RISE = 3'h7, PORT_FUNC = 3'h7;
   eic_pkg::eic_enables_t ENABLES = 4'h0;
   logic [3:0]  FLAG_WDATA = 4'hF, FLAGS;
   logic [15:0] NEXT_PC = 16'h0124, SP = 16'h1FF1, VEC_RDATA, STACK_ADDR, STACK_WDATA, VEC_ADDR, PC_VALUE;
   logic [7:0]  IRQ_VECTOR;
   logic IRQ_PENDING, ACCEPT, STACK_WR, SET_MASK, VEC_RD, PC_LOAD, HANDLER_START;
   int error_cnt = 0, n_compared = 0;
   always #5 CLK = ~CLK;
   eic_top DUT (.CLK(CLK), .RST_N(RST_N), .NMI_N(NMI_N), .PINS(PINS), .EDGE_RISE(EDGE_RISE),
      .PORT_FUNC(PORT_FUNC), .ENABLES(ENABLES), .FLAG_WR(FLAG_WR), .FLAG_WDATA(FLAG_WDATA),
      .DT_EVENT(DT_EVENT), .BREAK_REQ(BREAK_REQ), .MASK_BIT(MASK_BIT), .INSTR_DONE(INSTR_DONE),
      .RTE(RTE), .FIRST_INSTR_DONE(FIRST_INSTR_DONE), .NEXT_PC(NEXT_PC), .SP(SP),
      .VEC_RDATA(VEC_RDATA), .FLAGS(FLAGS), .IRQ_PENDING(IRQ_PENDING), .IRQ_VECTOR(IRQ_VECTOR),
      .ACCEPT(ACCEPT), .STACK_WR(STACK_WR), .STACK_ADDR(STACK_ADDR), .STACK_WDATA(STACK_WDATA),
      .SET_MASK(SET_MASK), .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR), .PC_LOAD(PC_LOAD),
      .PC_VALUE(PC_VALUE), .HANDLER_START(HANDLER_START));
   eic_cpu_model #(.PERIOD(4)) cpu (.clk(CLK), .rst_n(RST_N), .set_mask(SET_MASK), .rte(RTE),
      .vec_rd(VEC_RD), .vec_addr(VEC_ADDR), .instr_done(INSTR_DONE), .mask_bit(MASK_BIT),
      .vec_rdata(VEC_RDATA));
   // ***********************************
   // shared helpers
   // ***********************************
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge CLK);
         #1;
      end
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic clear_flags(input logic [3:0] d);
      FLAG_WDATA = d;
      FLAG_WR = 1'b1;
      tick(1);
      FLAG_WR = 1'b0;
      tick(2);
   endtask
   // wait for an acceptance, then follow the whole sequence cycle by cycle
   task automatic acc(input logic [7:0] vec);
      int n;
      logic m;
      n = 0;
      while (ACCEPT !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      chk("accept", 16'h1, ACCEPT);
      m = MASK_BIT;
      BREAK_REQ = 1'b0;
      NMI_N = 1'b1;
      for (int i = 1; i <= 14; i++) begin
         tick(1);
         chk("sequence", {i == 1 || i == 4, i == 4, i == 6, i == 7, i == 14},
             {STACK_WR, SET_MASK, VEC_RD, PC_LOAD, HANDLER_START});
         if (i == 1) chk("stack_pc_addr", (SP & 16'hFFFE) - 16'h0002, STACK_ADDR);
         if (i == 1) chk("stack_pc", NEXT_PC, STACK_WDATA);
         if (i == 4) chk("stack_ccr_addr", (SP & 16'hFFFE) - 16'h0004, STACK_ADDR);
         if (i == 4) chk("stack_ccr", {15'h0000, m}, STACK_WDATA);
         if (i == 6) chk("vec_addr", {7'h00, vec, 1'b0}, VEC_ADDR);
         if (i == 7) chk("pc_value", 16'hC000 | {7'h00, vec, 1'b0}, PC_VALUE);
      end
      chk("mask_after_entry", 16'h1, MASK_BIT);
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_reset_nmi();
      int seen;
      seen = 0;
      chk("flags_after_reset", 16'h0, FLAGS);
      chk("pending_after_reset", 16'h0, IRQ_PENDING);
      NMI_N = 1'b0;
      repeat (20) begin
         tick(1);
         if (ACCEPT === 1'b1) seen++;
      end
      chk("accept_before_first", 16'h0, 16'(seen));
      FIRST_INSTR_DONE = 1'b1;
      tick(1);
      FIRST_INSTR_DONE = 1'b0;
      acc(8'h07);
   endtask
   task automatic t_edges();
      for (int p = 0; p < 3; p++) begin
         for (int r = 0; r < 2; r++) begin
            EDGE_RISE[p] = r[0];
            PINS[p] = ~r[0];
            tick(6);
            clear_flags(4'h0);
            PINS[p] = r[0];
            tick(6);
            chk("flag_on_edge", 16'h1, FLAGS[2-p]);
            clear_flags(4'hF);
            chk("flag_write_one", 16'h1, FLAGS[2-p]);
            clear_flags(4'h0);
            chk("flag_write_zero", 16'h0, FLAGS[2-p]);
            PINS[p] = ~r[0];
            tick(6);
            chk("flag_wrong_edge", 16'h0, FLAGS[2-p]);
         end
      end
   endtask
   task automatic t_portfunc_dt();
      PORT_FUNC[2] = 1'b0;
      PINS[2] = 1'b1;
      tick(6);
      chk("flag_pin_not_func", 16'h0, FLAGS[0]);
      PINS[2] = 1'b0;
      PORT_FUNC[2] = 1'b1;
      tick(2);
      clear_flags(4'h0);
      tick(4);
      chk("flag_after_func_switch", 16'h0, FLAGS[0]);
      DT_EVENT = 1'b1;
      tick(1);
      DT_EVENT = 1'b0;
      tick(3);
      chk("dt_flag", 16'h8, FLAGS);
      clear_flags(4'h0);
   endtask
   task automatic t_priority();
      PINS = 3'h7;
      ENABLES = 4'hF;
      tick(8);
      ENABLES.enable_dt = 1'b0;
      tick(3);
      chk("flags_three", 16'h7, FLAGS);
      chk("vector_a_first", 16'h0E, IRQ_VECTOR);
      chk("no_accept_masked", 16'h0, ACCEPT);
      ENABLES.enable_a = 1'b0;
      tick(3);
      chk("vector_b_next", 16'h11, IRQ_VECTOR);
      ENABLES.enable_b = 1'b0;
      tick(3);
      chk("vector_wkp_next", 16'h12, IRQ_VECTOR);
      ENABLES.enable_wkp = 1'b0;
      tick(3);
      chk("none_enabled", 16'h0, IRQ_PENDING);
      ENABLES = 4'hB;
      RTE = 1'b1;
      tick(1);
      RTE = 1'b0;
      acc(8'h0E);
      clear_flags(4'hE);
      chk("b_still_pending", 16'h6, FLAGS);
      RTE = 1'b1;
      tick(1);
      RTE = 1'b0;
      acc(8'h11);
      BREAK_REQ = 1'b1;
      acc(8'h08);
      NMI_N = 1'b0;
      acc(8'h07);
      clear_flags(4'h0);
   endtask
   // ***********************************
   // verdict, watchdog and main sequence
   // ***********************************
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      tick(5);
      RST_N = 1'b1;
      tick(2);
      t_reset_nmi();
      t_edges();
      t_portfunc_dt();
      t_priority();
      report_and_stop();
   end
endmodule
`default_nettype wire
